// ==== exc_seq_pkg.sv ====
// constants and types shared by the exception sequencer
package exc_seq_pkg;
	localparam int          SRC_COUNT      = 8;           // hardware request lines
	localparam int          CODE_W         = 4;           // vector selector code width
	localparam int          PRESCALE_W     = 13;          // 12 stages plus overflow stage
	localparam logic [12:0] PRESCALE_RST   = 13'h0000;    // value after internal reset
	localparam logic [3:0]  CODE_RESET     = 4'h0;        // selector for reset vector
	localparam logic [3:0]  CODE_SWI       = 4'h1;        // selector for software interrupt
	localparam logic [3:0]  CODE_HW_BASE   = 4'h2;        // first hardware selector
	localparam logic [15:0] STACK_TOP_RST  = 16'h00FF;    // stack pointer after reset
	localparam int          STACK_BYTES    = 5;           // pcl, pch, x, a, ccr
	localparam logic [15:0] VECTOR_PAGE    = 16'hFFFE;    // reset vector high byte address

	// sequencer phases
	typedef enum logic [3:0] {
		ST_RUN,
		ST_DUMMY,
		ST_PUSH,
		ST_VECT_H,
		ST_VECT_L,
		ST_RET_PULL,
		ST_RET_PREFETCH
	} seq_state_t;
endpackage : exc_seq_pkg

// ==== exception_interrupt_sequencer.sv ====
// exception control: request latch, arbitration, entry and return sequencing, prescaler
`timescale 1ns/1ps
`default_nettype none
module exception_interrupt_sequencer
	import exc_seq_pkg::*;
#(
	parameter int N_SRC = SRC_COUNT                  // number of hardware request lines
)(
	input  wire logic              clk,
	input  wire logic              rst,              // internal reset, async high
	input  wire logic              ext_pin_reset,    // reset caused by the external pin
	input  wire logic [N_SRC-1:0]  irq_req,          // peripheral request lines, async
	input  wire logic [N_SRC-1:0]  irq_enable,       // per-source enables
	input  wire logic              insn_done,        // core finished an instruction
	input  wire logic              swi_exec,         // core decodes software interrupt
	input  wire logic              rti_exec,         // core decodes return instruction
	input  wire logic              brk_req,          // break request at instruction end
	input  wire logic              mask_flag_in,     // core global mask flag
	input  wire logic [15:0]       pc_in,            // core program counter
	input  wire logic [7:0]        acc_in,
	input  wire logic [7:0]        x_in,
	input  wire logic [7:0]        ccr_in,
	input  wire logic [7:0]        data_in,          // read data from memory
	output logic [15:0]            bus_addr,
	output logic [7:0]             bus_wdata,
	output logic                   bus_write,
	output logic                   bus_valid,
	output logic                   core_hold,        // stall core while sequencing
	output logic                   mask_set,         // one-cycle pulse: set global mask
	output logic [CODE_W-1:0]      vector_code,      // selector for vector fetch
	output logic [15:0]            restore_pc,
	output logic [7:0]             restore_acc,
	output logic [7:0]             restore_x,
	output logic [7:0]             restore_ccr,
	output logic                   restore_valid,    // one-cycle pulse at end of return
	output logic [PRESCALE_W-1:0]  prescale_count
);
	if (N_SRC < 1 || N_SRC > 14)
	begin : g_bad_src_count
		$error("N_SRC must be 1..14 to fit the selector code");
	end

	////////////////////////////////////////////////////////////////////////////
	// request synchronisers
	logic [N_SRC-1:0] req_s1_q;        // first stage, read only by second
	logic [N_SRC-1:0] req_s2_q;        // safe to use
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			req_s1_q <= '0;
			req_s2_q <= '0;
		end
		else
		begin
			req_s1_q <= irq_req;
			req_s2_q <= req_s1_q;
		end
	end

	// lowest index wins, as a fixed priority
	function automatic logic [CODE_W-1:0] pick(input logic [N_SRC-1:0] v);
		logic [CODE_W-1:0] c;
		c = '0;
		for (int i = N_SRC - 1; i >= 0; i--)
			if (v[i])
				c = CODE_W'(i) + CODE_HW_BASE;
		return c;
	endfunction : pick

	////////////////////////////////////////////////////////////////////////////
	// prescaler: counter clears on a clock edge on internal reset only, so a pin reset never races it; output register clears on any reset
	logic [PRESCALE_W-1:0] pre_q;
	always_ff @(posedge clk)
	begin
		if (rst && !ext_pin_reset)
			pre_q <= PRESCALE_RST;
		else
			pre_q <= pre_q + 1'b1;
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prescale_count <= '0;
		else
			prescale_count <= pre_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer
	seq_state_t       st_q;
	logic [2:0]       idx_q;              // byte index within push/pull
	logic [15:0]      sp_q;               // stack pointer
	logic [7:0]       stk_q [STACK_BYTES];// bytes to push (pcl,pch,x,a,ccr)
	logic             latched_q;          // a request is latched
	logic [CODE_W-1:0] code_q;
	logic [N_SRC-1:0] pend;
	assign pend = req_s2_q & irq_enable;
	logic [15:0]      pc_stack;
	assign pc_stack = swi_exec ? pc_in : pc_in - 16'h0001;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q          <= ST_RUN;
			idx_q         <= '0;
			sp_q          <= STACK_TOP_RST;
			latched_q     <= 1'b0;
			code_q        <= CODE_RESET;
			for (int k = 0; k < STACK_BYTES; k++)
				stk_q[k] <= 8'h00;
			bus_addr      <= 16'h0000;
			bus_wdata     <= 8'h00;
			bus_write     <= 1'b0;
			bus_valid     <= 1'b0;
			core_hold     <= 1'b0;
			mask_set      <= 1'b0;
			vector_code   <= CODE_RESET;       // reset selects reset vector
			restore_pc    <= 16'h0000;
			restore_acc   <= 8'h00;
			restore_x     <= 8'h00;
			restore_ccr   <= 8'h00;
			restore_valid <= 1'b0;
		end
		else
		begin
			mask_set      <= 1'b0;
			restore_valid <= 1'b0;
			bus_valid     <= 1'b0;
			bus_write     <= 1'b0;
			case (st_q)
			ST_RUN:
			begin
				if (insn_done)
				begin
					if (rti_exec)
					begin
						st_q      <= ST_RET_PULL;
						idx_q     <= '0;
						core_hold <= 1'b1;
					end
					else if (swi_exec || brk_req || (!mask_flag_in && |pend))
					begin
						// latch and arbitrate once; no later override
						if (!latched_q)
							code_q <= swi_exec ? CODE_SWI : (brk_req ? CODE_SWI : pick(pend));
						latched_q <= 1'b1;
						stk_q[0]  <= pc_stack[7:0];
						stk_q[1]  <= pc_stack[15:8];
						stk_q[2]  <= x_in;                   // no high index byte
						stk_q[3]  <= acc_in;
						stk_q[4]  <= ccr_in;
						st_q      <= ST_DUMMY;
						core_hold <= 1'b1;
					end
				end
			end
			ST_DUMMY:
			begin
				bus_addr  <= sp_q;                            // dummy cycle
				bus_valid <= 1'b1;
				idx_q     <= '0;
				st_q      <= ST_PUSH;
			end
			ST_PUSH:
			begin
				bus_addr  <= sp_q;                            // descending
				bus_wdata <= stk_q[idx_q];
				bus_write <= 1'b1;
				bus_valid <= 1'b1;
				sp_q      <= sp_q - 16'h0001;
				if (idx_q == 3'(STACK_BYTES - 1))
				begin
					mask_set    <= 1'b1;
					vector_code <= code_q;
					st_q        <= ST_VECT_H;
				end
				else
					idx_q <= idx_q + 3'd1;
			end
			ST_VECT_H:
			begin
				bus_addr  <= VECTOR_PAGE - {11'h000, code_q, 1'b0}; // high byte
				bus_valid <= 1'b1;
				st_q      <= ST_VECT_L;
			end
			ST_VECT_L:
			begin
				bus_addr  <= VECTOR_PAGE - {11'h000, code_q, 1'b0} + 16'h0001;
				bus_valid <= 1'b1;
				latched_q <= 1'b0;                            // serviced
				core_hold <= 1'b0;
				st_q      <= ST_RUN;
			end
			ST_RET_PULL:
			begin
				// pulls ascend: ccr, a, x, pch, pcl
				case (idx_q)
				3'd1: restore_ccr <= data_in;
				3'd2: restore_acc <= data_in;
				3'd3: restore_x   <= data_in;
				3'd4: restore_pc[15:8] <= data_in;
				default: ;
				endcase
				if (idx_q == 3'(STACK_BYTES))
				begin
					restore_pc[7:0] <= data_in;
					st_q            <= ST_RET_PREFETCH;
				end
				else
				begin
					bus_addr  <= sp_q + 16'h0001;
					bus_valid <= 1'b1;
					sp_q      <= sp_q + 16'h0001;
				end
				idx_q <= idx_q + 3'd1;
			end
			ST_RET_PREFETCH:
			begin
				bus_addr      <= {restore_pc[15:8], restore_pc[7:0]}; // always prefetch
				bus_valid     <= 1'b1;
				restore_valid <= 1'b1;
				// a pending request chains now if restored ccr bit 3 is clear, before the resumed opcode runs
				if (|pend && !restore_ccr[3])
				begin
					code_q    <= pick(pend);
					latched_q <= 1'b1;
					stk_q[0]  <= 8'(restore_pc - 16'h0001);
					stk_q[1]  <= 8'((restore_pc - 16'h0001) >> 8);
					stk_q[2]  <= restore_x;
					stk_q[3]  <= restore_acc;
					stk_q[4]  <= restore_ccr;
					st_q      <= ST_DUMMY;
				end
				else
				begin
					core_hold <= 1'b0;
					st_q      <= ST_RUN;
				end
			end
			default: st_q <= ST_RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	AST_MASK_AFTER_PUSH: assert property (@(posedge clk) disable iff (rst)
		(st_q == ST_PUSH && idx_q == 3'(STACK_BYTES - 1)) |=> mask_set)
		else $error("mask not set after stacking");
	AST_PUSH_DESC: assert property (@(posedge clk) disable iff (rst)
		(bus_write && $past(bus_write)) |-> bus_addr == $past(bus_addr) - 16'h0001)
		else $error("pushes not descending");
	AST_NO_MID_INSN: assert property (@(posedge clk) disable iff (rst)
		(st_q == ST_RUN && !insn_done) |=> !(st_q == ST_DUMMY))
		else $error("entry without instruction end");
	AST_VECT_ORDER: assert property (@(posedge clk) disable iff (rst)
		(st_q == ST_VECT_H) |=> (st_q == ST_VECT_L) ##1 !core_hold)
		else $error("vector low not after high");
	AST_HOLD_LATCH: assert property (@(posedge clk) disable iff (rst)
		(latched_q && st_q != ST_VECT_L && st_q != ST_RUN) |=> $stable(code_q))
		else $error("latched code overridden");
	AST_PRESCALE_RUN: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> pre_q == $past(pre_q) + 1'b1)
		else $error("prescaler stalled");
	AST_PREFETCH: assert property (@(posedge clk) disable iff (rst)
		(st_q == ST_RET_PREFETCH) |=> (bus_valid && restore_valid))
		else $error("return without prefetch");
	AST_FIVE_PUSH: assert property (@(posedge clk) disable iff (rst)
		(st_q == ST_DUMMY) |=> (st_q == ST_PUSH)[*5] ##1 st_q == ST_VECT_H)
		else $error("stacking count wrong");
	COV_HW: cover property (@(posedge clk) disable iff (rst) st_q == ST_VECT_L && code_q >= CODE_HW_BASE);
	COV_SWI: cover property (@(posedge clk) disable iff (rst) st_q == ST_VECT_L && code_q == CODE_SWI);
	COV_CHAIN: cover property (@(posedge clk) disable iff (rst) st_q == ST_RET_PREFETCH ##1 st_q == ST_DUMMY);
endmodule : exception_interrupt_sequencer
`default_nettype wire

// ==== core_mem_model.sv ====
// behavioural memory on the core side: stack page and vector bytes
`timescale 1ns/1ps
`default_nettype none
module core_mem_model
(
	input  wire logic        clk,
	input  wire logic [15:0] bus_addr,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic        bus_write,
	input  wire logic        bus_valid,
	output logic [7:0]       data_in
);
	logic [7:0] stack_mem [0:255];  // stack page, written by entry pushes
	logic [7:0] idle_q = 8'h5A;     // junk shown while no read stands
	////////////////////////////////////////////////////////////////////////
	// writes land on the edge; idle pattern keeps toggling
	always @(posedge clk)
	begin
		if (bus_valid && bus_write)
			stack_mem[bus_addr[7:0]] <= bus_wdata;
		idle_q <= ~idle_q;
	end
	// read data stands with its address, as the sequencer samples it at the next edge
	always_comb
	begin
		if (bus_valid && !bus_write)
			data_in = (bus_addr[15:8] == 8'hFF) ? ~bus_addr[7:0] : stack_mem[bus_addr[7:0]];
		else
			data_in = idle_q;
	end
endmodule : core_mem_model
`default_nettype wire

// ==== exception_interrupt_sequencer_tb_top.sv ====
// self-checking bench for the exception sequencer
`timescale 1ns/1ps
`default_nettype none
module exception_interrupt_sequencer_tb_top
	import exc_seq_pkg::*;
;
	logic        clk = 1'b0, rst = 1'b1, ext_pin_reset = 1'b0, insn_done = 1'b0, mask_flag_in = 1'b0;
	logic        swi_exec = 1'b0, rti_exec = 1'b0, brk_req = 1'b0;
	logic [7:0]  irq_req = 8'h00, irq_enable = 8'h00, acc_in = 8'h11, x_in = 8'h22, ccr_in = 8'h00;
	logic [15:0] pc_in = 16'h1234, sp = STACK_TOP_RST, p, bus_addr, restore_pc, rpc;
	logic [7:0]  data_in, bus_wdata, restore_acc, restore_x, restore_ccr, wd [0:15];
	logic        bus_write, bus_valid, core_hold, mask_set, restore_valid;
	logic [3:0]  vector_code, vc;
	logic [12:0] prescale_count;
	logic [23:0] rax;
	logic [15:0] wa [0:15], ra [0:15];
	int          wn, rn, ms, rv, pf, checked, fail_count, cyc;
	always #4 clk = ~clk;
	exception_interrupt_sequencer DUT (.clk(clk), .rst(rst), .ext_pin_reset(ext_pin_reset), .irq_req(irq_req),
		.irq_enable(irq_enable), .insn_done(insn_done), .swi_exec(swi_exec), .rti_exec(rti_exec),
		.brk_req(brk_req), .mask_flag_in(mask_flag_in), .pc_in(pc_in), .acc_in(acc_in), .x_in(x_in),
		.ccr_in(ccr_in), .data_in(data_in), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
		.bus_valid(bus_valid), .core_hold(core_hold), .mask_set(mask_set), .vector_code(vector_code),
		.restore_pc(restore_pc), .restore_acc(restore_acc), .restore_x(restore_x),
		.restore_ccr(restore_ccr), .restore_valid(restore_valid), .prescale_count(prescale_count));
	core_mem_model mem (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
		.bus_valid(bus_valid), .data_in(data_in));
	////////////////////////////////////////////////////////////////////////
	// bus monitor and hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (bus_valid === 1'b1 && bus_write === 1'b1 && wn < 16)
		begin
			wa[wn] = bus_addr;
			wd[wn] = bus_wdata;
			wn++;
		end
		if (bus_valid === 1'b1 && bus_write === 1'b0 && rn < 16)
		begin
			ra[rn] = bus_addr;
			rn++;
			if (bus_addr[15:8] == 8'hFF)
				vc = vector_code;
			if (bus_addr == 16'h1233 || bus_addr == 16'h1234)
				pf++;
		end
		if (mask_set === 1'b1)
			ms++;
		if (restore_valid === 1'b1)
		begin
			rv++;
			rpc = restore_pc;
			rax = {restore_acc, restore_x, restore_ccr};
		end
		if (cyc == 6000)
		begin
			fail_count++;
			give_verdict();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one instruction end, then wait until hold has been low for three cycles
	task automatic fire(input logic sw, input logic rt, input logic br);
		int q;
		@(negedge clk);
		wn = 0; rn = 0; ms = 0; rv = 0; pf = 0; vc = 4'hF;
		@(posedge clk);
		insn_done <= 1'b1; swi_exec <= sw; rti_exec <= rt; brk_req <= br;
		@(posedge clk);
		insn_done <= 1'b0; swi_exec <= 1'b0; rti_exec <= 1'b0; brk_req <= 1'b0;
		q = 0;
		for (int n = 0; n < 60 && q < 3; n++)
		begin
			@(posedge clk);
			q = (core_hold === 1'b1) ? 0 : q + 1;
		end
	endtask : fire
	task automatic chk_entry(input logic [15:0] epc, input logic [3:0] code);
		chk("push count", 5, wn);
		chk("push pcl", epc[7:0], wd[0]);
		chk("push pch", epc[15:8], wd[1]);
		chk("push regs", {x_in, acc_in, ccr_in}, {wd[2], wd[3], wd[4]});
		chk("push addrs", {sp, sp - 16'd4}, {wa[0], wa[4]});
		chk("mask pulse", 1, ms);
		chk("selector", code, vc);
		chk("vector reads", {VECTOR_PAGE - {code, 1'b0}, VECTOR_PAGE - {code, 1'b0} + 16'd1},
			{ra[rn-2], ra[rn-1]});
		sp = sp - 16'd5;
	endtask : chk_entry
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		@(negedge clk);
		chk("hold idle", 1'b0, core_hold);
		chk("reset selector", CODE_RESET, vector_code);
		p = prescale_count;
		repeat (5) @(negedge clk);
		chk("free count", p + 16'd5, prescale_count);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		repeat (2) @(negedge clk);
		chk("internal clear", PRESCALE_RST, prescale_count);
		repeat (40) @(negedge clk);
		p = prescale_count;
		@(posedge clk);
		rst <= 1'b1;
		ext_pin_reset <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		ext_pin_reset <= 1'b0;
		repeat (2) @(negedge clk);
		chk("pin keeps count", p + 16'd5, prescale_count);
		repeat (3) @(posedge clk);
		$display("reset test done");
	endtask : t_reset
	// masked and disabled requests are left alone
	task automatic t_gate;
		irq_req <= 8'h08;
		irq_enable <= 8'hFF;
		mask_flag_in <= 1'b1;
		repeat (3) @(posedge clk);
		fire(1'b0, 1'b0, 1'b0);
		chk("masked ignored", 0, wn + rn);
		mask_flag_in <= 1'b0;
		irq_enable <= 8'hF7;
		fire(1'b0, 1'b0, 1'b0);
		chk("disabled ignored", 0, wn + rn);
		$display("gate test done");
	endtask : t_gate
	// two pending sources, lower index wins; then return chains the other
	task automatic t_entry_return;
		irq_enable <= 8'hFF;
		irq_req <= 8'h48;
		repeat (6) @(negedge clk);
		chk("no entry mid instruction", 1'b0, core_hold);
		fire(1'b0, 1'b0, 1'b0);
		chk_entry(16'h1233, 4'h5);
		mask_flag_in <= 1'b1;
		irq_req <= 8'h40;
		fire(1'b0, 1'b1, 1'b0);
		chk("restore pulse", 1, rv);
		chk("restore pc", 16'h1233, rpc);
		chk("restore regs", {acc_in, x_in, ccr_in}, rax);
		chk("prefetch", 1'b1, pf > 0);
		sp = sp + 16'd5;
		chk_entry(16'h1232, 4'h8);
		irq_req <= 8'h00;
		$display("entry and return test done");
	endtask : t_entry_return
	task automatic t_soft;
		pc_in <= 16'h2000;
		fire(1'b1, 1'b0, 1'b0);
		chk_entry(16'h2000, CODE_SWI);
		fire(1'b0, 1'b0, 1'b1);
		chk("break selector", CODE_SWI, vc);
		$display("software interrupt test done");
	endtask : t_soft
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_reset();
		t_gate();
		t_entry_return();
		t_soft();
		give_verdict();
	end
endmodule : exception_interrupt_sequencer_tb_top
`default_nettype wire
